// [pkg/sxe_pkg.sv]
// Constants and types for the swap, skip, table-read and exclusive-or executor
package sxe_pkg;
  localparam int DATA_W  = 8;
  localparam int DADDR_W = 8;
  localparam int PADDR_W = 13;
  localparam int PWORD_W = 16;
  localparam int PAGE_W  = PADDR_W - DADDR_W;
  localparam int BIT_W   = 3;
  localparam int NIB_LO  = 0;
  localparam int NIB_HI  = 4;
  localparam int NIB_W   = 4;
  localparam int PLO_LSB = 0;
  localparam int PHI_LSB = 8;
  localparam logic [DATA_W-1:0]  WORK_RST  = 8'h00;
  localparam logic [DATA_W-1:0]  TABLE_HIGH_BYTE_REG_RST  = 8'h00;
  localparam logic [PAGE_W-1:0]  LAST_PAGE = 5'h1F;
  localparam logic [DATA_W-1:0]  ZERO_BYTE = 8'h00;

  // Operation codes presented by the sequencer
  typedef enum logic [3:0] {
    SXE_OP_NONE   = 4'h0,
    SXE_OP_SWAPW  = 4'h1,
    SXE_OP_SKZ    = 4'h2,
    SXE_OP_CPSKZ  = 4'h3,
    SXE_OP_SKBC   = 4'h4,
    SXE_OP_TRDS   = 4'h5,
    SXE_OP_TRDC   = 4'h6,
    SXE_OP_TRDL   = 4'h7,
    SXE_OP_XORW   = 4'h8,
    SXE_OP_EXCLUSIVE_OR_TO_MEMORY   = 4'h9,
    SXE_OP_XORI   = 4'hA
  } sxe_op_t;

  // One-hot sequencer states
  typedef enum logic [3:0] {
    SXE_ST_IDLE  = 4'b0001,
    SXE_ST_DREAD = 4'b0010,
    SXE_ST_PREAD = 4'b0100,
    SXE_ST_DUMMY = 4'b1000
  } sxe_state_t;
endpackage : sxe_pkg

// [pkg/sxe_alu_if.sv]
// Interface between executor control and its result logic
interface sxe_alu_if;
  sxe_pkg::sxe_op_t              op;
  logic [sxe_pkg::DATA_W-1:0]    work;
  logic [sxe_pkg::DATA_W-1:0]    mem;
  logic [sxe_pkg::DATA_W-1:0]    imm;
  logic [sxe_pkg::BIT_W-1:0]     bit_sel;
  logic [sxe_pkg::DATA_W-1:0]    result;
  logic                          skip;
  logic                          zero_upd;
  logic                          work_wr;
  logic                          mem_wr;
  modport ctrl (output op, work, mem, imm, bit_sel,
                input result, skip, zero_upd, work_wr, mem_wr);
  modport alu  (input op, work, mem, imm, bit_sel,
                output result, skip, zero_upd, work_wr, mem_wr);
endinterface : sxe_alu_if

// [rtl/sxe_alu.sv]
// Result, skip and write decisions for data-memory operations
module sxe_alu
(
  sxe_alu_if.alu a          // Operands in, decisions out
);
  // Function: byte equals zero
  function automatic logic sxe_is_zero(input logic [sxe_pkg::DATA_W-1:0] v);
    sxe_is_zero = (v == sxe_pkg::ZERO_BYTE);
  endfunction : sxe_is_zero

  // Decode op into result and side effects
  always_comb
  begin
    a.result   = a.mem;
    a.skip     = 1'b0;
    a.zero_upd = 1'b0;
    a.work_wr  = 1'b0;
    a.mem_wr   = 1'b0;
    case (a.op)
      sxe_pkg::SXE_OP_SWAPW:
      begin
        a.result = {a.mem[sxe_pkg::NIB_LO +: sxe_pkg::NIB_W],
                    a.mem[sxe_pkg::NIB_HI +: sxe_pkg::NIB_W]};
        a.work_wr = 1'b1;
      end
      sxe_pkg::SXE_OP_SKZ:
        a.skip = sxe_is_zero(a.mem);
      sxe_pkg::SXE_OP_CPSKZ:
      begin
        a.work_wr = 1'b1;
        a.skip    = sxe_is_zero(a.mem);
      end
      sxe_pkg::SXE_OP_SKBC:
        a.skip = ~a.mem[a.bit_sel];
      sxe_pkg::SXE_OP_XORW:
      begin
        a.result   = a.work ^ a.mem;
        a.work_wr  = 1'b1;
        a.zero_upd = 1'b1;
      end
      sxe_pkg::SXE_OP_EXCLUSIVE_OR_TO_MEMORY:
      begin
        a.result   = a.work ^ a.mem;
        a.mem_wr   = 1'b1;
        a.zero_upd = 1'b1;
      end
      sxe_pkg::SXE_OP_XORI:
      begin
        a.result   = a.work ^ a.imm;
        a.work_wr  = 1'b1;
        a.zero_upd = 1'b1;
      end
      default:
        a.result = a.mem;
    endcase
  end
endmodule : sxe_alu

// [rtl/sxe_exec.sv]
// Executor for swap, zero-skip, table-read and exclusive-or instructions
module sxe_exec
(
  input  wire logic                          mclk_in,        // System clock
  input  wire logic                          resetn_in,      // Sync reset, low
  input  wire logic                          start_in,       // Issue pulse
  input  wire logic [3:0]                    op_in,          // Operation code
  input  wire logic [sxe_pkg::DADDR_W-1:0]   maddr_in,       // Data address
  input  wire logic [sxe_pkg::DATA_W-1:0]    imm_in,         // Immediate byte
  input  wire logic [sxe_pkg::BIT_W-1:0]     bit_sel_in,     // Bit index
  input  wire logic [sxe_pkg::PAGE_W-1:0]    cur_page_in,    // Current page
  input  wire logic [sxe_pkg::DATA_W-1:0]    tbl_ptr_hi_in,  // Pointer high
  input  wire logic [sxe_pkg::DATA_W-1:0]    tbl_ptr_lo_in,  // Pointer low
  input  wire logic [sxe_pkg::DATA_W-1:0]    dmem_rdata_in,  // Data read value
  input  wire logic [sxe_pkg::PWORD_W-1:0]   pmem_rdata_in,  // Program word
  output logic      [sxe_pkg::DADDR_W-1:0]   dmem_addr_out,  // Data address
  output logic                               dmem_rd_out,    // Data read strobe
  output logic                               dmem_wr_out,    // Data write strobe
  output logic      [sxe_pkg::DATA_W-1:0]    dmem_wdata_out, // Data write value
  output logic      [sxe_pkg::PADDR_W-1:0]   pmem_addr_out,  // Program address
  output logic                               pmem_rd_out,    // Program read strobe
  output logic      [sxe_pkg::DATA_W-1:0]    work_out,       // Working register
  output logic      [sxe_pkg::DATA_W-1:0]    tbl_high_out,   // Table high byte
  output logic                               zero_flag_out,  // Zero flag
  output logic                               skip_out,       // Skip taken pulse
  output logic                               dummy_out,      // Dummy slot pulse
  output logic                               busy_out,       // Executing
  output logic                               done_out        // Completion pulse
);
  sxe_alu_if a ();

  sxe_pkg::sxe_state_t                   state;
  sxe_pkg::sxe_state_t                   next_state;
  sxe_pkg::sxe_op_t                      op_q;
  sxe_pkg::sxe_op_t                      next_op_q;
  logic [sxe_pkg::DATA_W-1:0]            imm_q;
  logic [sxe_pkg::DATA_W-1:0]            next_imm_q;
  logic [sxe_pkg::BIT_W-1:0]             bit_q;
  logic [sxe_pkg::BIT_W-1:0]             next_bit_q;
  logic [sxe_pkg::DATA_W-1:0]            working_register;
  logic [sxe_pkg::DATA_W-1:0]            next_working_register;
  logic [sxe_pkg::DATA_W-1:0]            table_high_byte_reg;
  logic [sxe_pkg::DATA_W-1:0]            next_table_high_byte_reg;
  logic                                  zero_flag;
  logic                                  next_zero_flag;
  logic [sxe_pkg::DADDR_W-1:0]           next_dmem_addr;
  logic                                  next_dmem_rd;
  logic                                  next_dmem_wr;
  logic [sxe_pkg::DATA_W-1:0]            next_dmem_wdata;
  logic [sxe_pkg::PADDR_W-1:0]           next_pmem_addr;
  logic                                  next_pmem_rd;
  logic                                  next_skip;
  logic                                  next_dummy;
  logic                                  next_done;
  sxe_pkg::sxe_op_t                      op_new;
  logic                                  issue;

  // Function: table-read op test
  function automatic logic sxe_is_table(input sxe_pkg::sxe_op_t o);
    sxe_is_table = (o == sxe_pkg::SXE_OP_TRDS) || (o == sxe_pkg::SXE_OP_TRDC)
                || (o == sxe_pkg::SXE_OP_TRDL);
  endfunction : sxe_is_table

  // Function: op needs a data read
  function automatic logic sxe_needs_mem(input sxe_pkg::sxe_op_t o);
    sxe_needs_mem = (o != sxe_pkg::SXE_OP_NONE) && (o != sxe_pkg::SXE_OP_XORI)
                 && !sxe_is_table(o);
  endfunction : sxe_needs_mem

  // Operand feed to result logic
  assign a.op      = op_q;
  assign a.work    = working_register;
  assign a.mem     = dmem_rdata_in;
  assign a.imm     = imm_q;
  assign a.bit_sel = bit_q;

  sxe_alu u_alu
  (
    .a (a.alu)
  );

  // Request taken this edge; a start while busy is dropped
  assign op_new = sxe_pkg::sxe_op_t'(op_in);
  assign issue  = start_in && (state == sxe_pkg::SXE_ST_IDLE);

  // Sequencer: state and latched request fields
  always_comb
  begin
    next_state = state;
    next_op_q  = op_q;
    next_imm_q = imm_q;
    next_bit_q = bit_q;
    case (state)
      sxe_pkg::SXE_ST_IDLE:
      begin
        if (issue)
        begin
          next_op_q  = op_new;
          next_imm_q = imm_in;
          next_bit_q = bit_sel_in;
          if (sxe_is_table(op_new))
            next_state = sxe_pkg::SXE_ST_PREAD;
          else if (sxe_needs_mem(op_new))
            next_state = sxe_pkg::SXE_ST_DREAD;
        end
      end
      sxe_pkg::SXE_ST_DREAD:
      begin
        // A taken skip spends one more slot
        if (a.skip)
          next_state = sxe_pkg::SXE_ST_DUMMY;
        else
          next_state = sxe_pkg::SXE_ST_IDLE;
      end
      sxe_pkg::SXE_ST_PREAD:
        next_state = sxe_pkg::SXE_ST_IDLE;
      sxe_pkg::SXE_ST_DUMMY:
        next_state = sxe_pkg::SXE_ST_IDLE;
      default:
        next_state = sxe_pkg::SXE_ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      state <= sxe_pkg::SXE_ST_IDLE;
      op_q  <= sxe_pkg::SXE_OP_NONE;
      imm_q <= sxe_pkg::ZERO_BYTE;
      bit_q <= '0;
    end
    else
    begin
      state <= next_state;
      op_q  <= next_op_q;
      imm_q <= next_imm_q;
      bit_q <= next_bit_q;
    end
  end

  // Working register, table high byte and zero flag
  always_comb
  begin
    next_working_register    = working_register;
    next_table_high_byte_reg = table_high_byte_reg;
    next_zero_flag           = zero_flag;
    case (state)
      sxe_pkg::SXE_ST_IDLE:
      begin
        // Immediate exclusive-or needs no memory cycle
        if (issue && (op_new == sxe_pkg::SXE_OP_XORI))
        begin
          next_working_register = working_register ^ imm_in;
          next_zero_flag        = ((working_register ^ imm_in) == sxe_pkg::ZERO_BYTE);
        end
      end
      sxe_pkg::SXE_ST_DREAD:
      begin
        // Read data is valid this cycle
        if (a.work_wr)
          next_working_register = a.result;
        if (a.zero_upd)
          next_zero_flag = (a.result == sxe_pkg::ZERO_BYTE);
      end
      sxe_pkg::SXE_ST_PREAD:
        next_table_high_byte_reg = pmem_rdata_in[sxe_pkg::PHI_LSB +: sxe_pkg::DATA_W];
      default:
        next_zero_flag = zero_flag;
    endcase
  end

  // Architectural registers
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      working_register    <= sxe_pkg::WORK_RST;
      table_high_byte_reg <= sxe_pkg::TABLE_HIGH_BYTE_REG_RST;
      zero_flag           <= 1'b0;
    end
    else
    begin
      working_register    <= next_working_register;
      table_high_byte_reg <= next_table_high_byte_reg;
      zero_flag           <= next_zero_flag;
    end
  end

  // Data and program memory port drive
  always_comb
  begin
    next_dmem_addr  = dmem_addr_out;
    next_dmem_rd    = 1'b0;
    next_dmem_wr    = 1'b0;
    next_dmem_wdata = dmem_wdata_out;
    next_pmem_addr  = pmem_addr_out;
    next_pmem_rd    = 1'b0;
    case (state)
      sxe_pkg::SXE_ST_IDLE:
      begin
        if (issue)
        begin
          next_dmem_addr = maddr_in;
          if (sxe_is_table(op_new))
          begin
            next_pmem_rd = 1'b1;
            case (op_new)
              sxe_pkg::SXE_OP_TRDS:
                next_pmem_addr = {tbl_ptr_hi_in[sxe_pkg::PAGE_W-1:0],
                                  tbl_ptr_lo_in};
              sxe_pkg::SXE_OP_TRDC:
                next_pmem_addr = {cur_page_in, tbl_ptr_lo_in};
              default:
                next_pmem_addr = {sxe_pkg::LAST_PAGE, tbl_ptr_lo_in};
            endcase
          end
          else if (sxe_needs_mem(op_new))
            next_dmem_rd = 1'b1;
        end
      end
      sxe_pkg::SXE_ST_DREAD:
      begin
        if (a.mem_wr)
        begin
          next_dmem_wr    = 1'b1;
          next_dmem_wdata = a.result;
        end
      end
      sxe_pkg::SXE_ST_PREAD:
      begin
        // Low byte of the program word goes to data memory
        next_dmem_wr    = 1'b1;
        next_dmem_wdata = pmem_rdata_in[sxe_pkg::PLO_LSB +: sxe_pkg::DATA_W];
      end
      default:
        next_dmem_rd = 1'b0;
    endcase
  end

  // Memory port registers
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      dmem_addr_out  <= '0;
      dmem_rd_out    <= 1'b0;
      dmem_wr_out    <= 1'b0;
      dmem_wdata_out <= sxe_pkg::ZERO_BYTE;
      pmem_addr_out  <= '0;
      pmem_rd_out    <= 1'b0;
    end
    else
    begin
      dmem_addr_out  <= next_dmem_addr;
      dmem_rd_out    <= next_dmem_rd;
      dmem_wr_out    <= next_dmem_wr;
      dmem_wdata_out <= next_dmem_wdata;
      pmem_addr_out  <= next_pmem_addr;
      pmem_rd_out    <= next_pmem_rd;
    end
  end

  // Skip, dummy-slot and completion pulses
  always_comb
  begin
    next_skip  = 1'b0;
    next_dummy = 1'b0;
    next_done  = 1'b0;
    case (state)
      sxe_pkg::SXE_ST_IDLE:
        next_done = issue && !sxe_is_table(op_new) && !sxe_needs_mem(op_new);
      sxe_pkg::SXE_ST_DREAD:
      begin
        next_skip  = a.skip;
        next_dummy = a.skip;
        next_done  = !a.skip;
      end
      sxe_pkg::SXE_ST_PREAD:
        next_done = 1'b1;
      sxe_pkg::SXE_ST_DUMMY:
        next_done = 1'b1;
      default:
        next_done = 1'b0;
    endcase
  end

  // Pulse registers
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      skip_out  <= 1'b0;
      dummy_out <= 1'b0;
      done_out  <= 1'b0;
    end
    else
    begin
      skip_out  <= next_skip;
      dummy_out <= next_dummy;
      done_out  <= next_done;
    end
  end

  // Registered views of internal state
  assign work_out      = working_register;
  assign tbl_high_out  = table_high_byte_reg;
  assign zero_flag_out = zero_flag;
  assign busy_out      = ~state[0];
endmodule : sxe_exec

// [verif/sxe_mem_model.sv]
// Behavioural data and program memories facing the executor
module sxe_mem_model
(
  input  wire logic        mclk_in,    // Clock
  input  wire logic [7:0]  daddr_in,   // Data address
  input  wire logic        drd_in,     // Data read strobe
  input  wire logic        dwr_in,     // Data write strobe
  input  wire logic [7:0]  dwdata_in,  // Data write value
  input  wire logic [12:0] paddr_in,   // Program address
  input  wire logic        prd_in,     // Program read strobe
  output logic      [7:0]  drdata_out, // Data read value
  output logic      [15:0] prdata_out  // Program word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [256];
  logic [15:0] pw;
  // Words follow the address; lines scrambled when not read
  assign pw         = {3'h5, paddr_in} ^ 16'h3C00;
  assign prdata_out = prd_in ? pw : ~pw;
  assign drdata_out = drd_in ? mem[daddr_in] : ~mem[daddr_in];
  // Write port; the bench also preloads cells directly
  always @(posedge mclk_in)
  begin
    if (dwr_in)
      mem[daddr_in] <= dwdata_in;
  end
endmodule : sxe_mem_model

// [verif/sxe_exec_sva.sv]
// Port-level checks for the executor
module sxe_exec_sva
(
  input wire logic        mclk_in,        // Clock
  input wire logic        resetn_in,      // Reset
  input wire logic        start_in,       // Issue
  input wire logic [3:0]  op_in,          // Op
  input wire logic [7:0]  imm_in,         // Immediate
  input wire logic [4:0]  cur_page_in,    // Page
  input wire logic [7:0]  tbl_ptr_hi_in,  // Pointer high
  input wire logic [7:0]  tbl_ptr_lo_in,  // Pointer low
  input wire logic [7:0]  dmem_rdata_in,  // Data read
  input wire logic [15:0] pmem_rdata_in,  // Program word
  input wire logic        dmem_rd_out,    // Data read strobe
  input wire logic        dmem_wr_out,    // Data write strobe
  input wire logic [7:0]  dmem_wdata_out, // Write value
  input wire logic [12:0] pmem_addr_out,  // Program address
  input wire logic        pmem_rd_out,    // Program strobe
  input wire logic [7:0]  work_out,       // Working register
  input wire logic [7:0]  tbl_high_out,   // Table high
  input wire logic        zero_flag_out,  // Zero flag
  input wire logic        skip_out,       // Skip
  input wire logic        dummy_out,      // Dummy slot
  input wire logic        busy_out,       // Busy
  input wire logic        done_out        // Done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  logic        take;
  logic [3:0]  lop;
  logic [12:0] pa;
  assign take = start_in && !busy_out;
  // Op and expected program address of the accepted request
  always_ff @(posedge mclk_in)
    if (!resetn_in) begin lop <= 4'h0; pa <= 13'h0000; end
    else if (take)
    begin
      lop <= op_in;
      pa  <= (op_in == 4'h5) ? {tbl_ptr_hi_in[4:0], tbl_ptr_lo_in} :
             (op_in == 4'h6) ? {cur_page_in, tbl_ptr_lo_in} : {5'h1F, tbl_ptr_lo_in};
    end
  sequence s_skip; skip_out && dummy_out ##1 done_out && !busy_out; endsequence
  sequence s_tbl; pmem_rd_out && busy_out ##1 dmem_wr_out && done_out; endsequence
  property p_rd; take && op_in inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9} |=> dmem_rd_out;
  endproperty
  a_rd: assert property (p_rd) else $error("data read missing");
  property p_skz; dmem_rd_out && lop == 4'h2 |=> skip_out == ($past(dmem_rdata_in) == 8'h00);
  endproperty
  a_skz: assert property (p_skz) else $error("zero skip wrong");
  property p_skip; skip_out |-> s_skip; endproperty
  a_skip: assert property (p_skip) else $error("skip slot wrong");
  property p_tbl; take && op_in inside {[4'h5:4'h7]} |=> s_tbl; endproperty
  a_tbl: assert property (p_tbl) else $error("table read steps wrong");
  property p_pa; pmem_rd_out |-> pmem_addr_out == pa; endproperty
  a_pa: assert property (p_pa) else $error("program address wrong");
  property p_split; dmem_wr_out && lop inside {[4'h5:4'h7]} |->
    dmem_wdata_out == $past(pmem_rdata_in[7:0]) && tbl_high_out == $past(pmem_rdata_in[15:8]);
  endproperty
  a_split: assert property (p_split) else $error("table bytes wrong");
  property p_swap; done_out && lop == 4'h1 |-> $stable(zero_flag_out) &&
    work_out == {$past(dmem_rdata_in[3:0]), $past(dmem_rdata_in[7:4])}; endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_xorw; done_out && lop == 4'h8 |->
    work_out == ($past(work_out) ^ $past(dmem_rdata_in));
  endproperty
  a_xorw: assert property (p_xorw) else $error("xor to work wrong");
  property p_exclusive_or_to_memory; dmem_wr_out && lop == 4'h9 |->
    dmem_wdata_out == ($past(work_out) ^ $past(dmem_rdata_in)); endproperty
  a_exclusive_or_to_memory: assert property (p_exclusive_or_to_memory) else $error("xor to memory wrong");
  property p_xori; take && op_in == 4'hA |=>
    done_out && work_out == ($past(work_out) ^ $past(imm_in));
  endproperty
  a_xori: assert property (p_xori) else $error("xor immediate wrong");
  property p_zero; done_out && lop inside {4'h8, 4'hA} |-> zero_flag_out == (work_out == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule : sxe_exec_sva
bind sxe_exec sxe_exec_sva u_sva (.mclk_in, .resetn_in, .start_in, .op_in, .imm_in, .cur_page_in,
  .tbl_ptr_hi_in, .tbl_ptr_lo_in, .dmem_rdata_in, .pmem_rdata_in, .dmem_rd_out, .dmem_wr_out,
  .dmem_wdata_out, .pmem_addr_out, .pmem_rd_out, .work_out, .tbl_high_out, .zero_flag_out,
  .skip_out, .dummy_out, .busy_out, .done_out);

// [verif/sxe_exec_tb_top.sv]
// Self-checking bench for the executor
module sxe_exec_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in = 1'b0, resetn_in = 1'b0, start_in = 1'b0, sk;
  logic [3:0]  op_in = 4'h0;
  logic [7:0]  maddr_in = 8'h00, imm_in = 8'h00, tbl_ptr_hi_in = 8'h00, tbl_ptr_lo_in = 8'h00;
  logic [2:0]  bit_sel_in = 3'h0;
  logic [4:0]  cur_page_in = 5'h00;
  logic [7:0]  dmem_rdata_in, dmem_addr_out, dmem_wdata_out, work_out, tbl_high_out, v;
  logic [15:0] pmem_rdata_in, pw;
  logic [12:0] pmem_addr_out;
  logic        dmem_rd_out, dmem_wr_out, pmem_rd_out, zero_flag_out, skip_out, dummy_out;
  logic        busy_out, done_out;
  int          fails = 0, checks_done = 0, ncyc;
  sxe_exec DUT (.mclk_in, .resetn_in, .start_in, .op_in, .maddr_in, .imm_in, .bit_sel_in,
    .cur_page_in, .tbl_ptr_hi_in, .tbl_ptr_lo_in, .dmem_rdata_in, .pmem_rdata_in,
    .dmem_addr_out, .dmem_rd_out, .dmem_wr_out, .dmem_wdata_out, .pmem_addr_out, .pmem_rd_out,
    .work_out, .tbl_high_out, .zero_flag_out, .skip_out, .dummy_out, .busy_out, .done_out);
  sxe_mem_model PM (.mclk_in, .daddr_in(dmem_addr_out), .drd_in(dmem_rd_out),
    .dwr_in(dmem_wr_out), .dwdata_in(dmem_wdata_out), .paddr_in(pmem_addr_out),
    .prd_in(pmem_rd_out), .drdata_out(dmem_rdata_in), .prdata_out(pmem_rdata_in));
  // Clock
  always #10 mclk_in = ~mclk_in;
  task automatic end_sim;
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One request; ncyc counts edges from the taking edge to the one raising done
  task automatic issue(input logic [3:0] op, input logic [7:0] a, x, input logic [2:0] b);
    @(posedge mclk_in); #1;
    start_in = 1'b1; op_in = op; maddr_in = a; imm_in = x; bit_sel_in = b;
    @(posedge mclk_in); #1;
    start_in = 1'b0; ncyc = 1; sk = 1'b0;
    while (done_out !== 1'b1)
    begin
      if (ncyc == 10) begin fails++; end_sim; end
      @(posedge mclk_in); #1;
      ncyc++;
      if (skip_out === 1'b1) sk = 1'b1;
    end
  endtask : issue
  // Memory is written at the edge after done
  task automatic mchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_in); #1;
    chk("dmem", PM.mem[a], exp);
  endtask : mchk
  task automatic t_xor;
    issue(4'hA, 8'h00, 8'h5A, 3'h0);
    chk("xori", work_out, 8'h5A);
    chk("xori cycles", ncyc, 1);
    chk("z nonzero", zero_flag_out, 1'b0);
    PM.mem[8'h20] = 8'h0F;
    PM.mem[8'h21] = 8'h55;
    issue(4'h8, 8'h20, 8'h00, 3'h0);
    chk("xorw", work_out, 8'h55);
    issue(4'h9, 8'h20, 8'h00, 3'h0);
    chk("exclusive_or_to_memory z", zero_flag_out, 1'b0);
    mchk(8'h20, 8'h5A);
    issue(4'h9, 8'h21, 8'h00, 3'h0);
    chk("exclusive_or_to_memory zero", zero_flag_out, 1'b1);
    chk("exclusive_or_to_memory work", work_out, 8'h55);
    mchk(8'h21, 8'h00);
    issue(4'hA, 8'h00, 8'h55, 3'h0);
    chk("xori zero", zero_flag_out, 1'b1);
  endtask : t_xor
  task automatic t_swap;
    PM.mem[8'h10] = 8'h3C;
    issue(4'h1, 8'h10, 8'h00, 3'h0);
    chk("swap", work_out, 8'hC3);
    chk("swap flag", zero_flag_out, 1'b1);
    mchk(8'h10, 8'h3C);
  endtask : t_swap
  task automatic t_skip;
    for (int op = 2; op < 4; op++)
      for (int k = 0; k < 3; k++)
      begin
        v = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : 8'h80;
        PM.mem[8'h30] = v;
        issue(op[3:0], 8'h30, 8'h00, 3'h0);
        chk("zero skip", sk, v == 8'h00);
        chk("skip cycles", ncyc, (v == 8'h00) ? 3 : 2);
        if (op == 3) chk("copy", work_out, v);
      end
    PM.mem[8'h31] = 8'hA5;
    for (int i = 0; i < 8; i++)
    begin
      issue(4'h4, 8'h31, 8'h00, i[2:0]);
      chk("bit skip", sk, !(8'hA5 >> i & 1));
      chk("bit cycles", ncyc, (8'hA5 >> i & 1) ? 2 : 3);
    end
  endtask : t_skip
  task automatic t_tbl;
    tbl_ptr_hi_in = 8'hE3;
    cur_page_in = 5'h0A;
    for (int op = 5; op < 8; op++)
    begin
      tbl_ptr_lo_in = 8'h70 + op[7:0];
      pw = {3'h5, (op == 5) ? 5'h03 : (op == 6) ? 5'h0A : 5'h1F, tbl_ptr_lo_in} ^ 16'h3C00;
      issue(op[3:0], 8'h40 + op[7:0], 8'h00, 3'h0);
      chk("table high", tbl_high_out, pw[15:8]);
      mchk(8'h40 + op[7:0], pw[7:0]);
    end
  endtask : t_tbl
  // Mid-run reset, then an immediate exclusive-or with zero
  task automatic t_reset;
    resetn_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    issue(4'hA, 8'h00, 8'h00, 3'h0);
    chk("rst work", work_out, 8'h00);
    chk("rst cycles", ncyc, 1);
    chk("rst zero", zero_flag_out, 1'b1);
  endtask : t_reset
  // Main sequence
  initial
  begin
    repeat (12) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    t_xor;
    t_swap;
    t_skip;
    t_tbl;
    t_reset;
    end_sim;
  end
endmodule : sxe_exec_tb_top
